// ===== dv/cpu_decode_checker_asserts.sv
// Assertion checker for the opcode decode and timing block
`timescale 1ns/100ps
`default_nettype none
module cpu_decode_checker (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       srst,
  // Opcode and fetch
  input wire logic                       op_valid,
  input wire logic [7:0]                 op_byte,
  input wire logic [15:0]                op_addr,
  input wire logic                       op_ready,
  input wire logic                       prog_rd_req,
  input wire logic [15:0]                prog_rd_addr,
  // Decode result and core state
  input wire logic                       dec_valid,
  input wire logic [7:0]                 dec_opcode,
  input wire logic [7:0]                 dec_operand1,
  input wire cpu_decode_pkg::dec_info_t  dec_info,
  input wire logic                       dec_page_cross,
  input wire logic [15:0]                dec_rel_target,
  input wire cpu_decode_pkg::core_regs_t core_regs,
  input wire logic [7:0]                 core_flags
);
  logic        take;
  logic [15:0] addr_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Opcode handshake
  assign take = op_valid && op_ready;
  // Address of the instruction in decode
  always_ff @(posedge clk_sys) begin
    if (srst) addr_q <= 16'h0000;
    else if (take) addr_q <= op_addr;
  end
  rom_call_a: assert property (
    take && op_byte == 8'h00 |-> ##2 dec_valid && dec_info == 9'h0BC)
    else $error("rom call decode wrong");
  halt_timing_a: assert property (
    take && op_byte == 8'h30 |-> ##2 dec_valid && dec_info == 9'h0A4)
    else $error("halt decode wrong");
  ready_drop_a: assert property (
    take |=> !op_ready) else $error("ready stayed high after take");
  fetch_next_a: assert property (
    take && op_byte == 8'h7C |=> prog_rd_req
      && prog_rd_addr == addr_q + 16'h0001)
    else $error("operand fetch address wrong");
  req_pulse_a: assert property (
    prog_rd_req |=> !prog_rd_req) else $error("fetch request too long");
  dec_pulse_a: assert property (
    dec_valid |-> op_ready ##1 !dec_valid)
    else $error("decode pulse or ready wrong");
  page_cross_a: assert property (
    dec_valid |-> dec_page_cross ==
      (({1'b0, addr_q[6:0]} + 8'(dec_info.length)) > 8'd128))
    else $error("page crossing flag wrong");
  rel_target_a: assert property (
    dec_valid && dec_opcode[7] |-> dec_rel_target == addr_q
      + {{4{dec_opcode[3]}}, dec_opcode[3:0], dec_operand1})
    else $error("relative target wrong");
  reset_state_a: assert property (disable iff (1'b0)
    srst |=> core_flags == 8'h02 && core_regs == 40'h0 && !dec_valid)
    else $error("reset state wrong");
  // Main scenarios reached
  cover property (take && op_byte == 8'h00);
  cover property (dec_valid && dec_page_cross);
  cover property (dec_valid && dec_info.length == 2'd3);
endmodule // cpu_decode_checker
bind cpu_opcode_decode_timing cpu_decode_checker cpu_decode_checker_inst (
  .clk_sys, .srst, .op_valid, .op_byte, .op_addr, .op_ready, .prog_rd_req,
  .prog_rd_addr, .dec_valid, .dec_opcode, .dec_operand1, .dec_info,
  .dec_page_cross, .dec_rel_target, .core_regs, .core_flags);
`default_nettype wire

// ===== dv/flash_model.sv
// Program flash model answering operand fetches
`timescale 1ns/100ps
`default_nettype none
module flash_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Fetch request and reply delay
  input  wire logic        prog_rd_req,
  input  wire logic [15:0] prog_rd_addr,
  input  wire logic [1:0]  lat,
  // Reply
  output logic             prog_rd_valid,
  output logic [7:0]       prog_rd_data
);
  logic        pend;
  logic [1:0]  cnt;
  logic [15:0] addr_q;
  // One reply per request; data inverts while idle
  always @(posedge clk_sys) begin
    prog_rd_valid <= 1'b0;
    prog_rd_data  <= ~prog_rd_data;
    if (srst) begin
      pend         <= 1'b0;
      prog_rd_data <= 8'h00;
    end else begin
      if (pend) begin
        if (cnt == 2'd0) begin
          prog_rd_valid <= 1'b1;
          prog_rd_data  <= addr_q[7:0] + 8'h11; // Byte content
          pend          <= 1'b0;
        end else cnt <= cnt - 2'd1;
      end
      if (prog_rd_req) begin
        pend   <= 1'b1;
        cnt    <= lat;
        addr_q <= prog_rd_addr;
      end
    end
  end
endmodule // flash_model
`default_nettype wire

// ===== dv/tb_cpu_opcode_decode_timing.sv
// Testbench for the opcode decode and timing block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb_cpu_opcode_decode_timing;
  logic clk_sys = 0, srst = 1, op_valid = 0, regs_wr = 0, flags_wr = 0;
  logic [7:0]  op_byte = 8'h00, flags_wdata = 8'h00, d1, d2;
  logic [15:0] op_addr = 16'h0000, prog_rd_addr, tgt;
  logic        op_ready, prog_rd_req, prog_rd_valid, dec_valid, pcr;
  logic [7:0]  prog_rd_data, opc, op1, op2, core_flags;
  logic [1:0]  lat = 2'd0;
  cpu_decode_pkg::dec_info_t  info;
  cpu_decode_pkg::core_regs_t regs_wdata = '0, core_regs;
  int num_errors = 0, total_checks = 0, cyc = 0;
  localparam logic [19:0] TBL [26] = '{
    20'h000BC, 20'h300A4,
    20'h071AB, 20'h01113,
    20'h2F1A9, 20'h421A9, 20'h70113,
    20'h5D119, 20'h60114, 20'h50111,
    20'h5F1A8, 20'h3E129, 20'h3F128,
    20'h6C123, 20'h7B123, 20'h18095, 20'h08090,
    20'h7C1B4, 20'h7E0AB, 20'hB5114, 20'h9A12C, 20'hF8135,
    20'h280AD, 20'h4E095, 20'h3D1A7, 20'h4A1A9};
  cpu_opcode_decode_timing cpu_opcode_decode_timing_inst (
    .clk_sys, .srst, .op_valid, .op_byte, .op_addr, .op_ready, .prog_rd_req,
    .prog_rd_addr, .prog_rd_valid, .prog_rd_data, .dec_valid,
    .dec_opcode(opc), .dec_operand1(op1), .dec_operand2(op2),
    .dec_info(info), .dec_page_cross(pcr), .dec_rel_target(tgt), .regs_wr,
    .regs_wdata, .flags_wr, .flags_wdata, .core_regs, .core_flags);
  flash_model flash_model_inst (.clk_sys, .srst, .prog_rd_req,
    .prog_rd_addr, .lat, .prog_rd_valid, .prog_rd_data);
  // Clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // Issue one opcode and judge its decode
  task automatic issue(input logic [7:0] op, input logic [8:0] inf,
                       input logic [15:0] a, input logic pc);
    int n;
    n = 0;
    d1 = a[7:0] + 8'h12;
    d2 = a[7:0] + 8'h13;
    while (op_ready !== 1'b1 && n < 40) begin
      @(posedge clk_sys); #1; n++;
    end
    op_valid = 1; op_byte = op; op_addr = a;
    @(posedge clk_sys); #1;
    op_valid = 0;
    while (dec_valid !== 1'b1 && n < 80) begin
      @(posedge clk_sys); #1; n++;
    end
    `CHK("dec_valid", 1'b1, dec_valid)
    `CHK("opcode", op, opc)
    `CHK("info", inf + (pc ? 9'h004 : 9'h000), info)
    `CHK("page_cross", pc, pcr)
    `CHK("operand1", (inf[8:7] > 1 ? d1 : 8'h00), op1)
    `CHK("operand2", (inf[8:7] > 2 ? d2 : 8'h00), op2)
    if (op[7]) `CHK("target", a + {{4{op[3]}}, op[3:0], d1}, tgt)
  endtask
  // Sample of 26 decode table entries, flash replies at delays of 0 to 2
  task automatic run_table();
    for (int i = 0; i < 26; i++) begin
      lat = 2'(i % 3);
      issue(TBL[i][19:12], TBL[i][8:0], 16'h0210 + 16'(i * 4), 1'b0);
    end
    $display("test table done");
  endtask
  // Instructions ending at or straddling a flash page edge
  task automatic page_edge();
    lat = 2'd1;
    issue(8'h7C, 9'h1B4, 16'h037F, 1'b1);
    issue(8'h50, 9'h111, 16'h047E, 1'b0);
    issue(8'h50, 9'h111, 16'h047F, 1'b1);
    issue(8'h00, 9'h0BC, 16'h057F, 1'b0);
    issue(8'hF8, 9'h135, 16'h067F, 1'b1);
    $display("test page edge done");
  endtask
  // Flag write masked by the last decode
  task automatic flag_wr(input logic [7:0] v, input logic [7:0] e);
    @(posedge clk_sys); #1;
    flags_wr = 1; flags_wdata = v;
    @(posedge clk_sys); #1;
    flags_wr = 0;
    `CHK("flags", e, core_flags)
  endtask
  task automatic flag_masks();
    issue(8'h01, 9'h113, 16'h0710, 1'b0);
    flag_wr(8'h04, 8'h04);
    issue(8'h2F, 9'h1A9, 16'h0720, 1'b0);
    flag_wr(8'h02, 8'h06);
    issue(8'h60, 9'h114, 16'h0730, 1'b0);
    flag_wr(8'h00, 8'h06);
    @(posedge clk_sys); #1;
    regs_wr = 1; regs_wdata = 40'h1122334455;
    @(posedge clk_sys); #1;
    regs_wr = 0;
    `CHK("regs", 40'h1122334455, core_regs)
    $display("test flag masks done");
  endtask
  // Reset during an operand fetch
  task automatic mid_reset();
    lat = 2'd3;
    op_valid = 1; op_byte = 8'h5F; op_addr = 16'h0810;
    @(posedge clk_sys); #1;
    op_valid = 0; srst = 1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 0;
    `CHK("flags", 8'h02, core_flags)
    `CHK("regs", 40'h0, core_regs)
    @(posedge clk_sys); #1;
    `CHK("ready", 1'b1, op_ready)
    issue(8'h5F, 9'h1A8, 16'h0820, 1'b0);
    $display("test mid reset done");
  endtask
  // Counts and verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 srst = 0;
    `CHK("flags", 8'h02, core_flags)
    @(posedge clk_sys); #1;
    `CHK("ready", 1'b1, op_ready)
    run_table();
    page_edge();
    flag_masks();
    mid_reset();
    end_sim();
  end
endmodule // tb_cpu_opcode_decode_timing
`default_nettype wire

// ===== rtl/cpu_decode_defs.svh
// Constants for the opcode decode and timing block
// Behaviour
// - Opcode 00, supervisory_rom_call, is one byte, 15 cycles, flags untouched.
// - Opcode 30, halt, is one byte, 9 cycles, flags untouched.
// - Add, add-with-carry, subtract, subtract_with_borrow update carry and zero.
// - Bitwise and, or, xor on accumulator or RAM update zero only.
// - Register-space logic ops with immediate: three bytes, 9 or 10 cycles, zero.
// - Flag-register logic ops: two bytes, 4 cycles, may change carry and zero.
// - Accumulator to register-space moves: 6,7 reads, 5,6 writes, 8,9 immediate.
// - Accumulator loads update zero; index loads and RAM stores leave flags.
// - Opcode 5F copies RAM to RAM: three bytes, 10 cycles, no flags.
// - Opcodes 3E and 3F: two bytes, 10 cycles, load form updates zero.
// - Shifts and rotates update carry and zero: 4, 7 or 8 cycles.
// - Increment and decrement update carry and zero: 4, 7 or 8 cycles.
// - Push takes 4 cycles, pop 5; only popping accumulator updates zero.
// - long_call 13, long_jump 7, return 8, interrupt_return 10 restoring flags.
// - Upper nibble 8 to F selects two-byte relative branches and cycle counts.
// - Opcode 28, program_memory_read, one byte, 11 cycles, updates zero.
// - compare sets zero on equal, carry on less, cycles 5,7,8,8,9.
// - mask_test is three bytes, updates zero only, 8, 9, 9 or 10 cycles.
// - One extra cycle when instruction bytes cross a 128-byte flash page.
// - Relative branches carry a 12-bit two's-complement displacement.
// - Reset clears accumulator, index, pc and stack pointer; flags load 02h.
`ifndef CPU_DECODE_DEFS_SVH
`define CPU_DECODE_DEFS_SVH

// Flash page size and the top bit of the in-page offset
`define FLASH_PAGE_BYTES   8'h80
`define FLASH_PAGE_MSB     6

// Relative branch displacement width
`define REL_DISP_BITS      12

// Extra cycle for a page crossing
`define PAGE_CROSS_CYCLES  5'h01

// Reset values of the core registers
`define ACC_RESET          8'h00
`define IDX_RESET          8'h00
`define PC_RESET           16'h0000
`define SP_RESET           8'h00
`define FLAGS_RESET        8'h02

// Flag bit positions
`define FLAG_CARRY_BIT     2
`define FLAG_ZERO_BIT      1

// Decoder state codes
`define ST_IDLE_CODE       2'b00
`define ST_RD1_CODE        2'b01
`define ST_RD2_CODE        2'b10
`define ST_EMIT_CODE       2'b11

`endif

// ===== rtl/cpu_decode_pkg.sv
// Types shared by the opcode decode and timing block
`include "cpu_decode_defs.svh"
package cpu_decode_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = `ST_IDLE_CODE,
    ST_RD1  = `ST_RD1_CODE,
    ST_RD2  = `ST_RD2_CODE,
    ST_EMIT = `ST_EMIT_CODE
  } dec_state_t;

  // Static facts about one opcode
  typedef struct packed {
    logic [1:0] length;
    logic [4:0] cycles;
    logic       upd_carry;
    logic       upd_zero;
  } dec_info_t;

  // Core register set
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [15:0] pc;
    logic [7:0]  sp;
  } core_regs_t;

endpackage

// ===== rtl/cpu_opcode_decode_timing.sv
// Opcode decoder with operand fetch, timing and core register state
`include "cpu_decode_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module cpu_opcode_decode_timing (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  // First opcode byte from the fetch unit
  input  wire logic                    op_valid,
  input  wire logic [7:0]              op_byte,
  input  wire logic [15:0]             op_addr,
  output logic                         op_ready,
  // Operand fetch from program flash
  output logic                         prog_rd_req,
  output logic [15:0]                  prog_rd_addr,
  input  wire logic                    prog_rd_valid,
  input  wire logic [7:0]              prog_rd_data,
  // Decoded instruction
  output logic                         dec_valid,
  output logic [7:0]                   dec_opcode,
  output logic [7:0]                   dec_operand1,
  output logic [7:0]                   dec_operand2,
  output cpu_decode_pkg::dec_info_t    dec_info,
  output logic                         dec_page_cross,
  output logic [15:0]                  dec_rel_target,
  // Core register writes from the execute unit
  input  wire logic                    regs_wr,
  input  wire cpu_decode_pkg::core_regs_t regs_wdata,
  input  wire logic                    flags_wr,
  input  wire logic [7:0]              flags_wdata,
  // Core register state
  output cpu_decode_pkg::core_regs_t   core_regs,
  output logic [7:0]                   core_flags
);

  cpu_decode_pkg::dec_state_t state_reg;
  cpu_decode_pkg::dec_state_t state_next;
  cpu_decode_pkg::dec_info_t  info_next;
  cpu_decode_pkg::dec_info_t  info_reg;
  logic [7:0]                 opcode_reg;
  logic [15:0]                addr_reg;
  logic [7:0]                 oper1_reg;
  logic [7:0]                 oper2_reg;
  logic                       cross_next;
  logic [7:0]                 span_end;
  logic [15:0]                disp_ext;
  logic                       op_take;
  logic                       op_ready_reg;
  logic                       rd_req_reg;
  logic [15:0]                rd_addr_reg;
  logic                       dec_valid_reg;
  cpu_decode_pkg::dec_info_t  dec_info_reg;
  logic                       dec_cross_reg;
  logic [15:0]                dec_target_reg;
  cpu_decode_pkg::core_regs_t regs_reg;
  logic [7:0]                 flags_reg;
  logic                       mask_carry_reg;
  logic                       mask_zero_reg;

  // Pack one table entry
  function automatic cpu_decode_pkg::dec_info_t mk(
    input logic [1:0] len,
    input logic [4:0] cyc,
    input logic       c,
    input logic       z
  );
    cpu_decode_pkg::dec_info_t r;
    r.length    = len;
    r.cycles    = cyc;
    r.upd_carry = c;
    r.upd_zero  = z;
    return r;
  endfunction

  // Regular arithmetic and logic forms by low three bits
  function automatic cpu_decode_pkg::dec_info_t alu_form(
    input logic [2:0] form,
    input logic       c
  );
    cpu_decode_pkg::dec_info_t r;
    case (form)
      3'h1:    r = mk(2'd2, 5'd4, c, 1'b1);
      3'h2:    r = mk(2'd2, 5'd6, c, 1'b1);
      3'h3:    r = mk(2'd2, 5'd7, c, 1'b1);
      3'h4:    r = mk(2'd2, 5'd7, c, 1'b1);
      3'h5:    r = mk(2'd2, 5'd8, c, 1'b1);
      3'h6:    r = mk(2'd3, 5'd9, c, 1'b1);
      3'h7:    r = mk(2'd3, 5'd10, c, 1'b1);
      default: r = mk(2'd1, 5'd4, 1'b0, 1'b0);
    endcase
    return r;
  endfunction

  // Table for opcodes 00 to 3F
  function automatic cpu_decode_pkg::dec_info_t low_table(
    input logic [7:0] op
  );
    cpu_decode_pkg::dec_info_t r;
    r = alu_form(op[2:0], ~op[5]);
    case (op)
      8'h00: r = mk(2'd1, 5'd15, 1'b0, 1'b0);
      8'h08: r = mk(2'd1, 5'd4, 1'b0, 1'b0);
      8'h10: r = mk(2'd1, 5'd4, 1'b0, 1'b0);
      8'h18: r = mk(2'd1, 5'd5, 1'b0, 1'b1);
      8'h20: r = mk(2'd1, 5'd5, 1'b0, 1'b0);
      8'h28: r = mk(2'd1, 5'd11, 1'b0, 1'b1);
      8'h30: r = mk(2'd1, 5'd9, 1'b0, 1'b0);
      8'h38: r = mk(2'd2, 5'd5, 1'b0, 1'b0);
      8'h39: r = mk(2'd2, 5'd5, 1'b1, 1'b1);
      8'h3A: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h3B: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h3C: r = mk(2'd3, 5'd8, 1'b1, 1'b1);
      8'h3D: r = mk(2'd3, 5'd9, 1'b1, 1'b1);
      8'h3E: r = mk(2'd2, 5'd10, 1'b0, 1'b1);
      8'h3F: r = mk(2'd2, 5'd10, 1'b0, 1'b0);
      default: r = r;
    endcase
    return r;
  endfunction

  // Table for opcodes 40 to 7F
  function automatic cpu_decode_pkg::dec_info_t mid_table(
    input logic [7:0] op
  );
    cpu_decode_pkg::dec_info_t r;
    case (op)
      8'h40: r = mk(2'd1, 5'd4, 1'b0, 1'b0);
      8'h41: r = mk(2'd3, 5'd9, 1'b0, 1'b1);
      8'h42: r = mk(2'd3, 5'd10, 1'b0, 1'b1);
      8'h43: r = mk(2'd3, 5'd9, 1'b0, 1'b1);
      8'h44: r = mk(2'd3, 5'd10, 1'b0, 1'b1);
      8'h45: r = mk(2'd3, 5'd9, 1'b0, 1'b1);
      8'h46: r = mk(2'd3, 5'd10, 1'b0, 1'b1);
      8'h47: r = mk(2'd3, 5'd8, 1'b0, 1'b1);
      8'h48: r = mk(2'd3, 5'd9, 1'b0, 1'b1);
      8'h49: r = mk(2'd3, 5'd9, 1'b0, 1'b1);
      8'h4A: r = mk(2'd3, 5'd10, 1'b0, 1'b1);
      8'h4B: r = mk(2'd1, 5'd5, 1'b0, 1'b1);
      8'h4C: r = mk(2'd2, 5'd7, 1'b0, 1'b1);
      8'h4D: r = mk(2'd2, 5'd7, 1'b0, 1'b0);
      8'h4E: r = mk(2'd1, 5'd5, 1'b0, 1'b1);
      8'h4F: r = mk(2'd1, 5'd4, 1'b0, 1'b0);
      8'h50: r = mk(2'd2, 5'd4, 1'b0, 1'b1);
      8'h51: r = mk(2'd2, 5'd5, 1'b0, 1'b1);
      8'h52: r = mk(2'd2, 5'd6, 1'b0, 1'b1);
      8'h53: r = mk(2'd2, 5'd5, 1'b0, 1'b0);
      8'h54: r = mk(2'd2, 5'd6, 1'b0, 1'b0);
      8'h55: r = mk(2'd3, 5'd8, 1'b0, 1'b0);
      8'h56: r = mk(2'd3, 5'd9, 1'b0, 1'b0);
      8'h57: r = mk(2'd2, 5'd4, 1'b0, 1'b0);
      8'h58: r = mk(2'd2, 5'd6, 1'b0, 1'b0);
      8'h59: r = mk(2'd2, 5'd7, 1'b0, 1'b0);
      8'h5A: r = mk(2'd2, 5'd5, 1'b0, 1'b0);
      8'h5B: r = mk(2'd1, 5'd4, 1'b0, 1'b1);
      8'h5C: r = mk(2'd1, 5'd4, 1'b0, 1'b0);
      8'h5D: r = mk(2'd2, 5'd6, 1'b0, 1'b1);
      8'h5E: r = mk(2'd2, 5'd7, 1'b0, 1'b1);
      8'h5F: r = mk(2'd3, 5'd10, 1'b0, 1'b0);
      8'h60: r = mk(2'd2, 5'd5, 1'b0, 1'b0);
      8'h61: r = mk(2'd2, 5'd6, 1'b0, 1'b0);
      8'h62: r = mk(2'd3, 5'd8, 1'b0, 1'b0);
      8'h63: r = mk(2'd3, 5'd9, 1'b0, 1'b0);
      8'h64: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h65: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h66: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h67: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h68: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h69: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h6A: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h6B: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h6C: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h6D: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h6E: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h6F: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h70: r = mk(2'd2, 5'd4, 1'b1, 1'b1);
      8'h71: r = mk(2'd2, 5'd4, 1'b1, 1'b1);
      8'h72: r = mk(2'd2, 5'd4, 1'b1, 1'b1);
      8'h73: r = mk(2'd1, 5'd4, 1'b0, 1'b1);
      8'h74: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h75: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h76: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h77: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h78: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h79: r = mk(2'd1, 5'd4, 1'b1, 1'b1);
      8'h7A: r = mk(2'd2, 5'd7, 1'b1, 1'b1);
      8'h7B: r = mk(2'd2, 5'd8, 1'b1, 1'b1);
      8'h7C: r = mk(2'd3, 5'd13, 1'b0, 1'b0);
      8'h7D: r = mk(2'd3, 5'd7, 1'b0, 1'b0);
      8'h7E: r = mk(2'd1, 5'd10, 1'b1, 1'b1);
      default: r = mk(2'd1, 5'd8, 1'b0, 1'b0); // 7F return
    endcase
    return r;
  endfunction

  // Relative branches chosen by the upper nibble
  function automatic cpu_decode_pkg::dec_info_t rel_table(
    input logic [3:0] nib
  );
    cpu_decode_pkg::dec_info_t r;
    case (nib)
      4'h9:    r = mk(2'd2, 5'd11, 1'b0, 1'b0);
      4'hE:    r = mk(2'd2, 5'd7, 1'b0, 1'b0);
      4'hF:    r = mk(2'd2, 5'd13, 1'b0, 1'b1);
      default: r = mk(2'd2, 5'd5, 1'b0, 1'b0);
    endcase
    return r;
  endfunction

  // Decode from the first byte alone
  always_comb begin
    if (op_byte[7]) begin
      info_next = rel_table(op_byte[7:4]);
    end else if (op_byte[6]) begin
      info_next = mid_table(op_byte);
    end else begin
      info_next = low_table(op_byte);
    end
  end

  // Last byte offset within the flash page
  assign span_end   = {1'b0, op_addr[`FLASH_PAGE_MSB:0]} +
                      {6'h00, info_next.length} - 8'h01;
  assign cross_next = span_end >= `FLASH_PAGE_BYTES;
  assign op_take    = op_valid && op_ready_reg;

  // Sign-extended 12-bit displacement from opcode and first operand
  assign disp_ext = {{(16 - `REL_DISP_BITS){opcode_reg[3]}},
                     opcode_reg[3:0], oper1_reg};

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpu_decode_pkg::ST_IDLE: begin
        if (op_take) begin
          state_next = (info_next.length == 2'd1) ? cpu_decode_pkg::ST_EMIT
                                                  : cpu_decode_pkg::ST_RD1;
        end
      end
      cpu_decode_pkg::ST_RD1: begin
        if (prog_rd_valid) begin
          state_next = (info_reg.length == 2'd3) ? cpu_decode_pkg::ST_RD2
                                                 : cpu_decode_pkg::ST_EMIT;
        end
      end
      cpu_decode_pkg::ST_RD2: begin
        if (prog_rd_valid) begin
          state_next = cpu_decode_pkg::ST_EMIT;
        end
      end
      cpu_decode_pkg::ST_EMIT: state_next = cpu_decode_pkg::ST_IDLE;
      default: state_next = cpu_decode_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= cpu_decode_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Capture opcode, address and table entry
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      opcode_reg <= 8'h00;
      addr_reg   <= 16'h0000;
      info_reg   <= '0;
    end else if (op_take) begin
      opcode_reg <= op_byte;
      addr_reg   <= op_addr;
      info_reg   <= info_next;
      info_reg.cycles <= info_next.cycles +
                         (cross_next ? `PAGE_CROSS_CYCLES : 5'h00);
    end
  end

  // Operand bytes from program flash
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      oper1_reg <= 8'h00;
      oper2_reg <= 8'h00;
    end else if (op_take) begin
      oper1_reg <= 8'h00;
      oper2_reg <= 8'h00;
    end else if (prog_rd_valid && state_reg == cpu_decode_pkg::ST_RD1) begin
      oper1_reg <= prog_rd_data;
    end else if (prog_rd_valid && state_reg == cpu_decode_pkg::ST_RD2) begin
      oper2_reg <= prog_rd_data;
    end
  end

  // Flash read request, one-cycle pulse per operand byte
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_req_reg  <= 1'b0;
      rd_addr_reg <= 16'h0000;
    end else if (op_take && info_next.length != 2'd1) begin
      rd_req_reg  <= 1'b1;
      rd_addr_reg <= op_addr + 16'h0001;
    end else if (prog_rd_valid && state_reg == cpu_decode_pkg::ST_RD1 &&
                 info_reg.length == 2'd3) begin
      rd_req_reg  <= 1'b1;
      rd_addr_reg <= addr_reg + 16'h0002;
    end else begin
      rd_req_reg  <= 1'b0;
    end
  end

  // Ready for a new opcode only while idle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_ready_reg <= 1'b0;
    end else begin
      op_ready_reg <= (state_next == cpu_decode_pkg::ST_IDLE) && !op_take;
    end
  end

  // Decoded result, valid for one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dec_valid_reg  <= 1'b0;
      dec_info_reg   <= '0;
      dec_cross_reg  <= 1'b0;
      dec_target_reg <= 16'h0000;
    end else begin
      dec_valid_reg <= (state_reg == cpu_decode_pkg::ST_EMIT);
      if (state_reg == cpu_decode_pkg::ST_EMIT) begin
        dec_info_reg   <= info_reg;
        dec_cross_reg  <= info_reg.cycles !=
                          mk_cycles_base(opcode_reg);
        dec_target_reg <= addr_reg + disp_ext;
      end
    end
  end

  // Uncrossed cycle count, used to report the page crossing
  function automatic logic [4:0] mk_cycles_base(input logic [7:0] op);
    cpu_decode_pkg::dec_info_t r;
    r = op[7] ? rel_table(op[7:4]) : (op[6] ? mid_table(op) : low_table(op));
    return r.cycles;
  endfunction

  // Flag mask of the instruction last handed out
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_carry_reg <= 1'b0;
      mask_zero_reg  <= 1'b0;
    end else if (state_reg == cpu_decode_pkg::ST_EMIT) begin
      mask_carry_reg <= info_reg.upd_carry;
      mask_zero_reg  <= info_reg.upd_zero;
    end
  end

  // Core registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regs_reg.acc <= `ACC_RESET;
      regs_reg.idx <= `IDX_RESET;
      regs_reg.pc  <= `PC_RESET;
      regs_reg.sp  <= `SP_RESET;
    end else if (regs_wr) begin
      regs_reg <= regs_wdata;
    end
  end

  // Flags: only the carry and zero bits the decode allows change
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_reg <= `FLAGS_RESET;
    end else if (flags_wr) begin
      if (mask_carry_reg) begin
        flags_reg[`FLAG_CARRY_BIT] <= flags_wdata[`FLAG_CARRY_BIT];
      end
      if (mask_zero_reg) begin
        flags_reg[`FLAG_ZERO_BIT] <= flags_wdata[`FLAG_ZERO_BIT];
      end
    end
  end

  // Outputs
  assign op_ready       = op_ready_reg;
  assign prog_rd_req    = rd_req_reg;
  assign prog_rd_addr   = rd_addr_reg;
  assign dec_valid      = dec_valid_reg;
  assign dec_opcode     = opcode_reg;
  assign dec_operand1   = oper1_reg;
  assign dec_operand2   = oper2_reg;
  assign dec_info       = dec_info_reg;
  assign dec_page_cross = dec_cross_reg;
  assign dec_rel_target = dec_target_reg;
  assign core_regs      = regs_reg;
  assign core_flags     = flags_reg;

endmodule // cpu_opcode_decode_timing
`default_nettype wire
